//--- smsr_receiver.sv
// Synchronous master serial receiver with AXI4-Lite register access
`timescale 1ns/1ps

// What this block does
// - In synchronous master mode with port enable set, reception starts when single or continuous enable is set.
// - Each data bit is sampled at the falling edge of the driven shift clock.
// - Single enable alone receives exactly one word, then clocking stops.
// - Continuous enable receives words back to back until software clears it.
// - With both enables set, continuous reception wins.
// - After the last bit the shift register moves into the buffer if room.
// - A transfer sets the receive complete flag; interrupt only when enabled.
// - Receive complete flag is read only and clears once the buffer is empty.
// - Receive buffer is a two-entry FIFO; two reads return both words.
// - Word finishing with full FIFO sets overrun and the word is lost.
// - Overrun clears only when software clears continuous enable.
// - While overrun is set no word enters the FIFO.
// - The ninth bit travels through the FIFO paired with its byte.
// - Reading the buffer updates ninth bit and framing status to the next word.
// - Ninth bit enable gives 9-bit words, otherwise 8-bit words.
// - Clearing both enables or port enable aborts and resets receive logic.
module smsr_receiver
    import smsr_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 2
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [SMSR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [SMSR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   serialDataPin,
    output logic                        serialClockOut,
    output logic                        serialClockOeN,
    output logic                        irq
);

    localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

    // Bus handshake state
    logic             awready_reg;
    logic             wready_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;
    logic             arready_reg;
    logic             rvalid_reg;
    logic [1:0]       rresp_reg;
    logic [31:0]      rdata_reg;
    // Software controls
    logic             portEnable_reg;
    logic             ninthEnable_reg;
    logic             singleEnable_reg;
    logic             contEnable_reg;
    logic             syncMode_reg;
    logic             clockMaster_reg;
    logic [7:0]       baud_reg;
    logic [1:0]       intEnable_reg;
    logic             overrun_reg;
    logic             ovrEvent_reg;
    logic             irq_reg;
    // Link side
    logic             dataMeta_reg;
    logic             dataSync_reg;
    smsr_rx_e         rxState_reg;
    logic [7:0]       baudCnt_reg;
    logic [3:0]       bitCnt_reg;
    logic [8:0]       shift_reg;
    logic             ninthLatch_reg;
    logic             sck_reg;
    logic             sckOeN_reg;
    // Receive FIFO
    smsr_word_s       fifoMem [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [CNT_W-1:0] fifoCount_reg;

    logic             wrEn;
    logic             wrLow;
    logic             rdEn;
    logic             wrCtrl;
    logic             crenClearWr;
    logic             rxEnable;
    logic             halfDone;
    logic             wordDone;
    logic             fifoFull;
    logic             pushWord;
    logic             popWord;
    logic             setOvr;
    logic             rxDone;
    logic [3:0]       lastBit;
    logic [8:0]       shift_next;
    smsr_word_s       rxWord;
    smsr_word_s       headWord;
    smsr_word_s       nextHead;
    logic [7:0]       rdMux;
    logic             rdMapped;
    logic             wrMapped;

    // Bus strobes; write data only counts where its low byte lane is enabled
    assign wrEn        = awready_reg & s_axi_awvalid & wready_reg & s_axi_wvalid;
    assign wrLow       = wrEn & s_axi_wstrb[0];
    assign rdEn        = arready_reg & s_axi_arvalid;
    assign wrCtrl      = wrLow && (s_axi_awaddr == SMSR_OFF_CTRL);
    assign crenClearWr = wrCtrl && !s_axi_wdata[SMSR_CTRL_CONT];

    // Receive qualifiers
    assign rxEnable   = portEnable_reg & syncMode_reg & clockMaster_reg
                      & (singleEnable_reg | contEnable_reg);
    assign lastBit    = ninthLatch_reg ? SMSR_LAST_BIT9 : SMSR_LAST_BIT8;
    assign halfDone   = (baudCnt_reg == 8'h00);
    assign shift_next = {dataSync_reg, shift_reg[8:1]};           // LSB first
    assign wordDone   = (rxState_reg == RX_CLK_HI) && halfDone && rxEnable
                      && (bitCnt_reg == lastBit);
    assign fifoFull   = (fifoCount_reg == CNT_FULL);
    assign popWord    = rdEn && (s_axi_araddr == SMSR_OFF_RXBUF) && (fifoCount_reg != '0);
    // A pop in the same cycle frees a slot, so that case is not an overrun
    assign pushWord   = wordDone && !overrun_reg && (!fifoFull || popWord);
    assign setOvr     = wordDone && !overrun_reg && fifoFull && !popWord;
    assign rxDone     = (fifoCount_reg != '0);

    // Word assembly keeps the ninth bit beside its byte
    always_comb begin
        rxWord.framing_error_bit = 1'b0;                 // No stop bit in synchronous mode
        if (ninthLatch_reg) begin
            rxWord.ninth = shift_next[8];
            rxWord.data  = shift_next[7:0];
        end else begin
            rxWord.ninth = 1'b0;
            rxWord.data  = shift_next[8:1];
        end
    end

    assign headWord = rxDone ? fifoMem[rdPtr_reg] : '0;
    // Word behind the head; becomes the head after the next pop
    assign nextHead = fifoMem[(rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1];

    // Data pin synchroniser; only the second stage feeds logic
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataMeta_reg <= 1'b0;
            dataSync_reg <= 1'b0;
        end else begin
            dataMeta_reg <= serialDataPin;
            dataSync_reg <= dataMeta_reg;
        end
    end

    // Write address and data are taken together, one write outstanding
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else if (!awready_reg && s_axi_awvalid && s_axi_wvalid && !bvalid_reg) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
        end else begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end
    end

    // Write response; unmapped offsets answer with a slave error
    always_comb begin
        unique case (s_axi_awaddr)
            SMSR_OFF_CTRL, SMSR_OFF_MODE, SMSR_OFF_BAUD,
            SMSR_OFF_RXBUF, SMSR_OFF_FLAG, SMSR_OFF_IEN: wrMapped = 1'b1;
            default:                                     wrMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= SMSR_RESP_OKAY;
        end else if (wrEn) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wrMapped ? SMSR_RESP_OKAY : SMSR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data mux; the buffer offset pops the FIFO head
    always_comb begin
        rdMux    = 8'h00;
        rdMapped = 1'b1;
        unique case (s_axi_araddr)
            SMSR_OFF_CTRL: begin
                rdMux[SMSR_CTRL_PORT_EN] = portEnable_reg;
                rdMux[SMSR_CTRL_NINE_EN] = ninthEnable_reg;
                rdMux[SMSR_CTRL_SINGLE]  = singleEnable_reg;
                rdMux[SMSR_CTRL_CONT]    = contEnable_reg;
                rdMux[SMSR_CTRL_FRAMING_ERROR_BIT]    = headWord.framing_error_bit;
                rdMux[SMSR_CTRL_OVERRUN_ERROR_BIT]    = overrun_reg;
                rdMux[SMSR_CTRL_NINE_RX] = headWord.ninth;
            end
            SMSR_OFF_MODE: begin
                rdMux[SMSR_MODE_SYNC] = syncMode_reg;
                rdMux[SMSR_MODE_CLOCK_SOURCE_MASTER] = clockMaster_reg;
            end
            SMSR_OFF_BAUD:  rdMux = baud_reg;
            SMSR_OFF_RXBUF: rdMux = headWord.data;
            SMSR_OFF_FLAG: begin
                rdMux[SMSR_FLAG_RXDONE] = rxDone;
                rdMux[SMSR_FLAG_OVR]    = ovrEvent_reg;
            end
            SMSR_OFF_IEN:   rdMux = {6'h00, intEnable_reg};
            default:        rdMapped = 1'b0;
        endcase
    end

    // Read channel, one read outstanding
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= SMSR_RESP_OKAY;
            rdata_reg   <= 32'h00000000;
        end else begin
            arready_reg <= !arready_reg && s_axi_arvalid && !rvalid_reg;
            if (rdEn) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= rdMapped ? SMSR_RESP_OKAY : SMSR_RESP_SLVERR;
                rdata_reg  <= {24'h000000, rdMux};
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Control register; hardware drops single enable after its one word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            portEnable_reg   <= 1'b0;
            ninthEnable_reg  <= 1'b0;
            singleEnable_reg <= 1'b0;
            contEnable_reg   <= 1'b0;
        end else if (wrCtrl) begin
            portEnable_reg   <= s_axi_wdata[SMSR_CTRL_PORT_EN];
            ninthEnable_reg  <= s_axi_wdata[SMSR_CTRL_NINE_EN];
            singleEnable_reg <= s_axi_wdata[SMSR_CTRL_SINGLE];
            contEnable_reg   <= s_axi_wdata[SMSR_CTRL_CONT];
        end else if (wordDone && !contEnable_reg) begin
            singleEnable_reg <= 1'b0;
        end
    end

    // Mode, baud and interrupt enable registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syncMode_reg    <= 1'b0;
            clockMaster_reg <= 1'b0;
            baud_reg        <= SMSR_RST_BAUD;
            intEnable_reg   <= SMSR_RST_IEN;
        end else if (wrLow) begin
            if (s_axi_awaddr == SMSR_OFF_MODE) begin
                syncMode_reg    <= s_axi_wdata[SMSR_MODE_SYNC];
                clockMaster_reg <= s_axi_wdata[SMSR_MODE_CLOCK_SOURCE_MASTER];
            end
            if (s_axi_awaddr == SMSR_OFF_BAUD) begin
                baud_reg <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == SMSR_OFF_IEN) begin
                intEnable_reg <= s_axi_wdata[1:0];
            end
        end
    end

    // Overrun latch; set wins over the clearing write in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overrun_reg <= 1'b0;
        end else if (setOvr) begin
            overrun_reg <= 1'b1;
        end else if (crenClearWr) begin
            overrun_reg <= 1'b0;
        end
    end

    // Sticky overrun event, write one to clear, set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovrEvent_reg <= 1'b0;
        end else if (setOvr) begin
            ovrEvent_reg <= 1'b1;
        end else if (wrLow && (s_axi_awaddr == SMSR_OFF_FLAG)
                     && s_axi_wdata[SMSR_FLAG_OVR]) begin
            ovrEvent_reg <= 1'b0;
        end
    end

    // Level interrupt, one cycle behind the flags it gates
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |({ovrEvent_reg, rxDone} & intEnable_reg);
        end
    end

    // Shift clock sequencer: high half, falling edge samples, low half
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxState_reg    <= RX_IDLE;
            baudCnt_reg    <= 8'h00;
            bitCnt_reg     <= 4'h0;
            shift_reg      <= 9'h000;
            ninthLatch_reg <= 1'b0;
            sck_reg        <= 1'b0;
            sckOeN_reg     <= 1'b1;
        end else if (!rxEnable) begin
            rxState_reg <= RX_IDLE;
            bitCnt_reg  <= 4'h0;
            sck_reg     <= 1'b0;
            sckOeN_reg  <= 1'b1;
        end else begin
            unique case (rxState_reg)
                RX_IDLE: begin
                    rxState_reg    <= RX_CLK_HI;
                    baudCnt_reg    <= baud_reg;
                    bitCnt_reg     <= 4'h0;
                    ninthLatch_reg <= ninthEnable_reg;
                    sck_reg        <= 1'b1;
                    sckOeN_reg     <= 1'b0;
                end
                RX_CLK_HI: begin
                    if (halfDone) begin
                        rxState_reg <= RX_CLK_LO;
                        baudCnt_reg <= baud_reg;
                        shift_reg   <= shift_next;
                        bitCnt_reg  <= bitCnt_reg + 4'h1;
                        sck_reg     <= 1'b0;
                    end else begin
                        baudCnt_reg <= baudCnt_reg - 8'h01;
                    end
                end
                RX_CLK_LO: begin
                    if (!halfDone) begin
                        baudCnt_reg <= baudCnt_reg - 8'h01;
                    end else begin
                        rxState_reg <= RX_CLK_HI;
                        baudCnt_reg <= baud_reg;
                        sck_reg     <= 1'b1;
                        if (bitCnt_reg > lastBit) begin
                            bitCnt_reg     <= 4'h0;
                            ninthLatch_reg <= ninthEnable_reg;
                        end
                    end
                end
            endcase
        end
    end

    // FIFO storage; data is not reset, only the pointers are
    always_ff @(posedge clock) begin
        if (pushWord) begin
            fifoMem[wrPtr_reg] <= rxWord;
        end
    end

    // FIFO pointers and occupancy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_reg     <= '0;
            rdPtr_reg     <= '0;
            fifoCount_reg <= '0;
        end else begin
            if (pushWord) begin
                wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
            end
            if (popWord) begin
                rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
            end
            if (pushWord && !popWord) begin
                fifoCount_reg <= fifoCount_reg + 1'b1;
            end else if (popWord && !pushWord) begin
                fifoCount_reg <= fifoCount_reg - 1'b1;
            end
        end
    end

    assign s_axi_awready  = awready_reg;
    assign s_axi_wready   = wready_reg;
    assign s_axi_bvalid   = bvalid_reg;
    assign s_axi_bresp    = bresp_reg;
    assign s_axi_arready  = arready_reg;
    assign s_axi_rvalid   = rvalid_reg;
    assign s_axi_rresp    = rresp_reg;
    assign s_axi_rdata    = rdata_reg;
    assign serialClockOut = sck_reg;
    assign serialClockOeN = sckOeN_reg;
    assign irq            = irq_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence falling_sample_s;
        (rxState_reg == RX_CLK_HI) && halfDone && rxEnable;
    endsequence

    sequence word_end_s;
        wordDone && !contEnable_reg && !wrCtrl;
    endsequence

    start_on_enable_a: assert property ((rxState_reg == RX_IDLE) && rxEnable
        |=> (rxState_reg == RX_CLK_HI) && sck_reg && !sckOeN_reg)
        else $error("reception did not start after enable");
    sample_at_fall_a: assert property (falling_sample_s
        |=> $fell(sck_reg) && (shift_reg[8] == $past(dataSync_reg)))
        else $error("data bit not taken at falling clock edge");
    single_stop_a: assert property (word_end_s
        |=> !singleEnable_reg ##1 (rxState_reg == RX_IDLE) && sckOeN_reg)
        else $error("single reception kept clocking");
    continuous_run_a: assert property (wordDone && contEnable_reg && !wrCtrl
        |=> (rxState_reg == RX_CLK_LO) ##1 ((rxState_reg != RX_IDLE) || !$past(rxEnable)))
        else $error("continuous reception stopped");
    word_transfer_a: assert property (wordDone && !overrun_reg && !fifoFull && !popWord
        |=> fifoCount_reg == $past(fifoCount_reg) + 1'b1)
        else $error("finished word not moved into buffer");
    flag_after_push_a: assert property (pushWord |=> rxDone)
        else $error("receive complete flag not set");
    flag_clears_a: assert property (popWord && (fifoCount_reg == 1) && !pushWord
        |=> !rxDone)
        else $error("receive complete flag stuck after last read");
    fifo_bound_a: assert property (fifoCount_reg <= CNT_FULL)
        else $error("buffer holds too many words");
    overrun_set_a: assert property (wordDone && !overrun_reg && fifoFull && !popWord
        |=> overrun_reg && $stable(fifoCount_reg))
        else $error("overrun not flagged on full buffer");
    overrun_hold_a: assert property (overrun_reg && !crenClearWr |=> overrun_reg)
        else $error("overrun cleared without clearing continuous enable");
    overrun_block_a: assert property (overrun_reg |-> !pushWord)
        else $error("word entered buffer during overrun");
    ninth_follow_a: assert property (popWord && (fifoCount_reg == 2) && !pushWord
        |=> headWord == $past(nextHead))
        else $error("status not advanced to next word");
    word_length_a: assert property ((rxState_reg == RX_IDLE) && rxEnable
        |=> ninthLatch_reg == $past(ninthEnable_reg))
        else $error("word length does not match ninth bit enable");
    abort_reset_a: assert property (!rxEnable |=> (rxState_reg == RX_IDLE)
        && (bitCnt_reg == 4'h0))
        else $error("receive logic not reset on disable");
    clock_idle_a: assert property ((rxState_reg == RX_IDLE) |-> sckOeN_reg && !sck_reg)
        else $error("shift clock driven while idle");

endmodule

//--- smsr_pkg.sv
// Shared constants, field layout and types of the synchronous master serial receiver
package smsr_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam int unsigned SMSR_ADDR_W    = 5;
    localparam logic [4:0]  SMSR_OFF_CTRL  = 5'h00;
    localparam logic [4:0]  SMSR_OFF_MODE  = 5'h04;
    localparam logic [4:0]  SMSR_OFF_BAUD  = 5'h08;
    localparam logic [4:0]  SMSR_OFF_RXBUF = 5'h0C;
    localparam logic [4:0]  SMSR_OFF_FLAG  = 5'h10;
    localparam logic [4:0]  SMSR_OFF_IEN   = 5'h14;

    // Field positions of the receive status and control register
    localparam int unsigned SMSR_CTRL_PORT_EN = 7;
    localparam int unsigned SMSR_CTRL_NINE_EN = 6;
    localparam int unsigned SMSR_CTRL_SINGLE  = 5;
    localparam int unsigned SMSR_CTRL_CONT    = 4;
    localparam int unsigned SMSR_CTRL_FRAMING_ERROR_BIT    = 2;
    localparam int unsigned SMSR_CTRL_OVERRUN_ERROR_BIT    = 1;
    localparam int unsigned SMSR_CTRL_NINE_RX = 0;

    // Field positions of the mode register
    localparam int unsigned SMSR_MODE_SYNC = 0;
    localparam int unsigned SMSR_MODE_CLOCK_SOURCE_MASTER = 1;

    // Field positions of the flag and interrupt enable registers
    localparam int unsigned SMSR_FLAG_RXDONE = 0;
    localparam int unsigned SMSR_FLAG_OVR    = 1;

    // Reset values
    localparam logic [7:0] SMSR_RST_BAUD = 8'h00;
    localparam logic [1:0] SMSR_RST_IEN  = 2'h0;

    // Bus responses
    localparam logic [1:0] SMSR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SMSR_RESP_SLVERR = 2'h2;

    // Index of the last bit of an 8-bit and of a 9-bit word
    localparam logic [3:0] SMSR_LAST_BIT8 = 4'h7;
    localparam logic [3:0] SMSR_LAST_BIT9 = 4'h8;

    // One received word as held in the receive buffer
    typedef struct packed {
        logic       ninth;
        logic       framing_error_bit;
        logic [7:0] data;
    } smsr_word_s;

    // Shift clock sequencer states
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_CLK_HI,
        RX_CLK_LO
    } smsr_rx_e;

endpackage

//--- smsr_partner.sv
// Serial word source at the far end of the receiver's data pin
`timescale 1ns/1ps
module smsr_partner (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       sck,
    input  wire logic       oeN,
    input  wire logic       nine,
    input  wire logic [8:0] base,
    output logic            sd
);
    logic [3:0] bitIdx;
    logic [7:0] wordIdx;
    logic       sckOld;
    logic       tog;
    logic [8:0] word;
    // Each word differs from the last so lost or repeated words show up
    assign word = {base[8] ^ wordIdx[0], base[7:0] + wordIdx * 8'h3B};
    // Unselected line toggles so a stale sample never passes; LSB first
    assign sd = oeN ? tog : word[bitIdx];
    // Advance one bit after each falling shift clock edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {bitIdx, wordIdx, sckOld, tog} <= '0;
        end else begin
            sckOld <= sck;
            tog    <= ~tog;
            if (oeN) begin
                bitIdx <= 4'h0;
            end else if (sckOld && !sck) begin
                bitIdx <= (bitIdx == (nine ? 4'h8 : 4'h7)) ? 4'h0 : bitIdx + 4'h1;
                if (bitIdx == (nine ? 4'h8 : 4'h7)) wordIdx <= wordIdx + 8'h01;
            end
        end
    end
endmodule

//--- smsr_receiver_bench.sv
// Self-checking bench for the synchronous master serial receiver
`timescale 1ns/1ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin numErrors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module smsr_receiver_bench import smsr_pkg::*; ;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, nine;
    logic        awready, wready, bvalid, arready, rvalid, sd, sck, oeN, irq;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [8:0]  base, w;
    int          numErrors, totalChecks, cycles, i;
    smsr_receiver i_smsr_receiver (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serialDataPin(sd), .serialClockOut(sck),
        .serialClockOeN(oeN), .irq(irq));
    smsr_partner i_smsr_partner (.clock(clock), .rst(rst), .sck(sck), .oeN(oeN),
        .nine(nine), .base(base), .sd(sd));
    // Word k that the partner sends, worked out independently
    function automatic logic [8:0] expWord(input int k);
        return {base[8] ^ k[0], base[7:0] + 8'(k) * 8'h3B};
    endfunction
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1;
        fork
            begin do @(posedge clock); while (awready !== 1'b1); awvalid <= 1'b0; end
            begin do @(posedge clock); while (wready !== 1'b1); wvalid <= 1'b0; end
        join
        bready <= 1'b1;
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0; r = bresp;
    endtask
    task automatic rd(input logic [4:0] a);
        araddr <= a; arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0; rready <= 1'b1;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0; d = rdata; r = rresp;
    endtask
    task automatic reportAndStop();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin numErrors++; reportAndStop(); end
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, nine} = 7'h40;
        {awaddr, araddr, wdata} = '0;
        i = $urandom(69);
        base = 9'($urandom);
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        // Single 8-bit word: baud 3 gives the 800 ns link period
        wr(SMSR_OFF_BAUD, 8'h03); wr(SMSR_OFF_MODE, 8'h03); wr(SMSR_OFF_IEN, 8'h01);
        wr(SMSR_OFF_CTRL, 8'hA0);
        for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clock);
        `CHK(irq, 1'b1)
        rd(SMSR_OFF_FLAG); `CHK(d[0], 1'b1)
        rd(SMSR_OFF_CTRL); `CHK(d[5], 1'b0)
        `CHK({oeN, sck}, 2'b10)
        w = expWord(0);
        rd(SMSR_OFF_RXBUF); `CHK(d, {24'h0, w[7:0]})
        rd(SMSR_OFF_FLAG); `CHK(d[0], 1'b0)
        // Both enables, 9-bit words, masked interrupt, run into overrun
        wr(SMSR_OFF_IEN, 8'h00); nine <= 1'b1; wr(SMSR_OFF_CTRL, 8'hF0);
        d = '0;
        for (i = 0; i < 200 && d[1] !== 1'b1; i++) rd(SMSR_OFF_CTRL);
        `CHK(d[1], 1'b1)
        `CHK(irq, 1'b0)
        wr(SMSR_OFF_CTRL, 8'hC0);
        repeat (4) @(posedge clock);
        `CHK(oeN, 1'b1)
        rd(SMSR_OFF_FLAG); `CHK(d[1:0], 2'b11)
        // Unmasking the sticky overrun event raises the line one cycle later
        wr(SMSR_OFF_IEN, 8'h02); @(posedge clock); `CHK(irq, 1'b1)
        w = expWord(1);
        rd(SMSR_OFF_CTRL); `CHK(d[1:0], {1'b0, w[8]})
        rd(SMSR_OFF_RXBUF); `CHK(d[7:0], w[7:0])
        w = expWord(2);
        rd(SMSR_OFF_CTRL); `CHK(d[0], w[8])
        rd(SMSR_OFF_RXBUF); `CHK(d[7:0], w[7:0])
        wr(SMSR_OFF_FLAG, 8'h02); rd(SMSR_OFF_FLAG); `CHK(d[1:0], 2'b00)
        wr(5'h18, 8'hFF); `CHK(r, SMSR_RESP_SLVERR)
        rd(5'h18); `CHK(r, SMSR_RESP_SLVERR)
        reportAndStop();
    end
endmodule
